// ---- logic/acdt_pkg.sv ----
/*
  Shared constants and carrier types of the alarm comparator and countdown timer.
  Assumes a 20 MHz reference clock and a 32.768 kHz time base derived from it.
*/
`default_nettype none
package acdt_pkg;
  // ------------------------------------------------------------
  // clock rates
  // ------------------------------------------------------------
  localparam int unsigned REF_HZ = 20_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned REF_PERIOD_NS = 50;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_SECONDS = 5'h04;
  localparam logic [4:0] ADDR_SEC_MATCH = 5'h0B;
  localparam logic [4:0] ADDR_MIN_MATCH = 5'h0C;
  localparam logic [4:0] ADDR_HOUR_MATCH = 5'h0D;
  localparam logic [4:0] ADDR_DAY_MATCH = 5'h0E;
  localparam logic [4:0] ADDR_WDAY_MATCH = 5'h0F;
  localparam logic [4:0] ADDR_CD_LOAD = 5'h10;
  localparam logic [4:0] ADDR_CD_CTRL = 5'h11;
  localparam logic [4:0] ADDR_LAST = 5'h11;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int unsigned MATCH_DIS_BIT = 7;
  localparam logic [7:0] SEC_VAL_MASK = 8'h7F;
  localparam logic [7:0] HOUR_VAL_MASK = 8'h3F;
  localparam logic [7:0] DAY_VAL_MASK = 8'h3F;
  localparam logic [7:0] WDAY_VAL_MASK = 8'h07;
  localparam logic [7:0] MATCH_RESET = 8'h80;
  localparam logic [7:0] CD_LOAD_RESET = 8'h00;
  localparam logic [7:0] CD_CTRL_RESET = 8'h18;
  localparam int unsigned CTRL_SRC_LSB = 3;
  localparam int unsigned CTRL_RUN_BIT = 2;
  localparam int unsigned CTRL_IE_BIT = 1;
  localparam int unsigned CTRL_PULSE_BIT = 0;
  localparam logic [1:0] CMD_SUBADDR = 2'h1;
  // ------------------------------------------------------------
  // source selection and pulse widths in 32.768 kHz ticks
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SRC_4096 = 2'h0, SRC_64 = 2'h1, SRC_1HZ = 2'h2, SRC_MIN = 2'h3}
    acdt_src_t;
  localparam logic [9:0] PW_4096_T1 = 10'h004;
  localparam logic [9:0] PW_4096 = 10'h008;
  localparam logic [9:0] PW_64_T1 = 10'h100;
  localparam logic [9:0] PW_SLOW = 10'h200;
  localparam logic [5:0] SECS_PER_MIN_M1 = 6'h3B;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] wday;
  } acdt_time_t;
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [7:0] data;
  } acdt_wr_t;
endpackage
`default_nettype wire

// ---- logic/acdt_spi.sv ----
/*
  Three-wire serial register port: command byte, then auto-incrementing data bytes.
  Assumes synchronised chip enable, serial clock and data levels on the local clock.
*/
`timescale 1ns/100ps
`default_nettype none
module acdt_spi (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sdi_i,
  input wire logic [7:0] rdata_i,
  output var acdt_pkg::acdt_wr_t wr_o,
  output logic [4:0] addr_o,
  output logic busy_o,
  output logic sdo_o,
  output logic sdo_oe_n_o
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_CMD = 2'h1, ST_DATA = 2'h3, ST_SKIP = 2'h2}
    acdt_spi_st_t;
  acdt_spi_st_t state;
  logic scl_d;
  logic rise;
  logic fall;
  logic [2:0] bit_cnt;
  logic [7:0] shin;
  logic [7:0] next_byte;
  logic rd_mode;

  assign rise = ce_i & scl_i & ~scl_d;
  assign fall = ce_i & ~scl_i & scl_d;
  assign next_byte = {shin[6:0], sdi_i};
  assign busy_o = (state == ST_DATA);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d <= 1'b0;
    end else begin
      scl_d <= scl_i;
    end
  end

  // ------------------------------------------------------------
  // command and write bytes
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shin <= 8'h00;
      addr_o <= 5'h00;
      rd_mode <= 1'b0;
      wr_o <= '0;
    end else begin
      wr_o.valid <= 1'b0;
      if (!ce_i) begin
        state <= ST_IDLE;
        bit_cnt <= 3'h0;
      end else if (state == ST_IDLE) begin
        state <= ST_CMD;
      end else if (rise) begin
        shin <= next_byte;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          case (state)
            ST_CMD: begin
              if (next_byte[6:5] == acdt_pkg::CMD_SUBADDR &&
                  next_byte[4:0] <= acdt_pkg::ADDR_LAST) begin // [R23]
                state <= ST_DATA;
                rd_mode <= next_byte[7];
                addr_o <= next_byte[4:0];
              end else begin
                state <= ST_SKIP;
              end
            end
            ST_DATA: begin
              wr_o.valid <= ~rd_mode;
              wr_o.addr <= addr_o;
              wr_o.data <= next_byte;
              addr_o <= (addr_o == acdt_pkg::ADDR_LAST) ? 5'h00 : addr_o + 5'h01;
            end
            default: begin
              state <= state;
            end
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read bytes, changed on the falling serial clock
  // ------------------------------------------------------------
  logic [7:0] shout;
  assign sdo_o = shout[7];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shout <= 8'h00;
      sdo_oe_n_o <= 1'b1;
    end else if (!ce_i || state != ST_DATA || !rd_mode) begin
      sdo_oe_n_o <= 1'b1;
    end else if (fall) begin
      sdo_oe_n_o <= 1'b0;
      shout <= (bit_cnt == 3'h0) ? rdata_i : {shout[6:0], 1'b0};
    end
  end
endmodule // acdt_spi
`default_nettype wire

// ---- logic/acdt_top.sv ----
/*
  Alarm comparator and 8-bit countdown timer with its serial register port.
  Assumes calendar counters outside that advance on TIME_TICK_O and present the time.
*/
// Notes on behaviour
// [R1] host reads time as one burst from seconds
// [R2] bit 7 set excludes that alarm field
// [R3] all enabled fields matching sets alarm flag
// [R4] alarm flag sticky; refires only on fresh match
// [R5] alarm enable mirrors flag onto interrupt
// [R6] seconds, minutes match values are BCD
// [R7] hour match layout per 12/24 mode
// [R8] day BCD, weekday 0 to 6
// [R9] two bits select timer source, reset 11
// [R10] control bits run, irq enable, pulse mode
// [R11] load value zero halts counting
// [R12] reaching one sets flag and reloads
// [R13] new load value takes effect immediately
// [R14] host should stop timer before reloading
// [R15] timer flag sticky; interrupt level or pulse
// [R16] first period after enable is uncertain
// [R17] reading load address returns live count
// [R18] host reads live count twice to agree
// [R19] pulse width by source and load value
// [R20] slow sources take offset correction steps
// [R21] host selects slowest source when idle
// [R22] time held during access; one pending tick
// [R23] command byte: read bit, subaddress, index
// [R24] alarm evaluated once per time update
`timescale 1ns/100ps
`default_nettype none
module acdt_top (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_N_O,
  output logic INT_O,
  output logic INT_OE_N_O,
  input wire acdt_pkg::acdt_time_t TIME_I,
  input wire logic [7:0] EXT_RDATA_I,
  output logic [4:0] EXT_RD_ADDR_O,
  output var acdt_pkg::acdt_wr_t EXT_WR_O,
  output logic TIME_TICK_O,
  input wire logic ALARM_IRQ_ENABLE_I,
  input wire logic ALARM_FLAG_CLEAR_I,
  input wire logic COUNTDOWN_FLAG_CLEAR_I,
  input wire logic CORR_ADD_I,
  input wire logic CORR_DROP_I,
  output logic ALARM_FLAG_O,
  output logic COUNTDOWN_FLAG_O
);
  localparam int unsigned ACC_W = 25;
  if (acdt_pkg::REF_HZ >= (2 ** ACC_W) || acdt_pkg::OSC_HZ >= acdt_pkg::REF_HZ) begin : g_bad_rate
    $error("reference rate cannot serve the time base");
  end
  localparam logic [ACC_W-1:0] OSC_STEP = ACC_W'(acdt_pkg::OSC_HZ);
  localparam logic [ACC_W-1:0] REF_WRAP = ACC_W'(acdt_pkg::REF_HZ);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {CE_I, SCL_I, SDIO_I};
      pin_s2 <= pin_s1;
    end
  end

  // ------------------------------------------------------------
  // serial register port
  // ------------------------------------------------------------
  acdt_pkg::acdt_wr_t wr;
  logic [4:0] addr;
  logic busy;
  logic [7:0] rdata;
  logic sdo;
  logic sdo_oe_n;
  acdt_spi u_spi (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .ce_i(pin_s2[2]),
    .scl_i(pin_s2[1]),
    .sdi_i(pin_s2[0]),
    .rdata_i(rdata),
    .wr_o(wr),
    .addr_o(addr),
    .busy_o(busy),
    .sdo_o(sdo),
    .sdo_oe_n_o(sdo_oe_n)
  );
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SDIO_O <= 1'b0;
      SDIO_OE_N_O <= 1'b1;
      EXT_RD_ADDR_O <= 5'h00;
      EXT_WR_O <= '0;
    end else begin
      SDIO_O <= sdo;
      SDIO_OE_N_O <= sdo_oe_n;
      EXT_RD_ADDR_O <= addr;
      EXT_WR_O <= wr;
      EXT_WR_O.valid <= wr.valid && wr.addr < acdt_pkg::ADDR_SEC_MATCH;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] sec_match;
  logic [7:0] min_match;
  logic [7:0] hour_match;
  logic [7:0] day_match;
  logic [7:0] wday_match;
  logic [7:0] cd_load;
  logic [7:0] cd_ctrl;
  logic [7:0] cd_count;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sec_match <= acdt_pkg::MATCH_RESET; // [R2]
      min_match <= acdt_pkg::MATCH_RESET;
      hour_match <= acdt_pkg::MATCH_RESET;
      day_match <= acdt_pkg::MATCH_RESET;
      wday_match <= acdt_pkg::MATCH_RESET;
      cd_load <= acdt_pkg::CD_LOAD_RESET;
      cd_ctrl <= acdt_pkg::CD_CTRL_RESET; // [R9]
    end else if (wr.valid) begin
      case (wr.addr)
        acdt_pkg::ADDR_SEC_MATCH: sec_match <= wr.data & (acdt_pkg::SEC_VAL_MASK | 8'h80); // [R6]
        acdt_pkg::ADDR_MIN_MATCH: min_match <= wr.data & (acdt_pkg::SEC_VAL_MASK | 8'h80);
        acdt_pkg::ADDR_HOUR_MATCH: hour_match <= wr.data & (acdt_pkg::HOUR_VAL_MASK | 8'h80); // [R7]
        acdt_pkg::ADDR_DAY_MATCH: day_match <= wr.data & (acdt_pkg::DAY_VAL_MASK | 8'h80); // [R8]
        acdt_pkg::ADDR_WDAY_MATCH: wday_match <= wr.data & (acdt_pkg::WDAY_VAL_MASK | 8'h80);
        acdt_pkg::ADDR_CD_LOAD: cd_load <= wr.data;
        acdt_pkg::ADDR_CD_CTRL: cd_ctrl <= wr.data & 8'h1F; // [R10]
        default: cd_load <= cd_load;
      endcase
    end
  end

  always_comb begin
    case (addr)
      acdt_pkg::ADDR_SEC_MATCH: rdata = sec_match;
      acdt_pkg::ADDR_MIN_MATCH: rdata = min_match;
      acdt_pkg::ADDR_HOUR_MATCH: rdata = hour_match;
      acdt_pkg::ADDR_DAY_MATCH: rdata = day_match;
      acdt_pkg::ADDR_WDAY_MATCH: rdata = wday_match;
      acdt_pkg::ADDR_CD_LOAD: rdata = cd_count; // [R17]
      acdt_pkg::ADDR_CD_CTRL: rdata = cd_ctrl;
      default: rdata = EXT_RDATA_I; // [R1]
    endcase
  end

  logic cd_run;
  logic cd_ie;
  logic cd_pulse_mode;
  acdt_pkg::acdt_src_t cd_src;
  assign cd_run = cd_ctrl[acdt_pkg::CTRL_RUN_BIT];
  assign cd_ie = cd_ctrl[acdt_pkg::CTRL_IE_BIT];
  assign cd_pulse_mode = cd_ctrl[acdt_pkg::CTRL_PULSE_BIT];
  assign cd_src = acdt_pkg::acdt_src_t'(cd_ctrl[acdt_pkg::CTRL_SRC_LSB +: 2]);

  // ------------------------------------------------------------
  // time base: 32.768 kHz enable and its divisions
  // ------------------------------------------------------------
  logic [ACC_W-1:0] phase;
  logic [ACC_W-1:0] next_phase;
  logic osc_tick;
  logic [14:0] prescale;
  logic [5:0] sec_cnt;
  assign next_phase = phase + OSC_STEP;
  assign osc_tick = (next_phase >= REF_WRAP);
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase <= '0;
      prescale <= 15'h0000;
      sec_cnt <= 6'h00;
    end else begin
      phase <= osc_tick ? next_phase - REF_WRAP : next_phase;
      if (osc_tick) begin
        prescale <= prescale + 15'h0001;
        if (prescale == 15'h7FFF) begin
          sec_cnt <= (sec_cnt == acdt_pkg::SECS_PER_MIN_M1) ? 6'h00 : sec_cnt + 6'h01;
        end
      end
    end
  end
  logic tick_4096;
  logic tick_64;
  logic tick_1hz;
  logic tick_1hz_corr;
  logic tick_min;
  logic src_tick;
  assign tick_4096 = osc_tick & (prescale[2:0] == 3'h7);
  assign tick_64 = osc_tick & (prescale[8:0] == 9'h1FF);
  assign tick_1hz = osc_tick & (prescale == 15'h7FFF);
  assign tick_1hz_corr = (tick_1hz & ~CORR_DROP_I) | CORR_ADD_I; // [R20]
  assign tick_min = tick_1hz_corr & (sec_cnt == 6'h00);
  always_comb begin
    case (cd_src)
      acdt_pkg::SRC_4096: src_tick = tick_4096;
      acdt_pkg::SRC_64: src_tick = tick_64;
      acdt_pkg::SRC_1HZ: src_tick = tick_1hz_corr;
      default: src_tick = tick_min;
    endcase
  end

  // ------------------------------------------------------------
  // time update held while an access runs
  // ------------------------------------------------------------
  logic tick_pending;
  logic eval_tick;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_pending <= 1'b0;
      TIME_TICK_O <= 1'b0;
      eval_tick <= 1'b0;
    end else begin
      TIME_TICK_O <= ~busy & (tick_1hz | tick_pending); // [R22]
      if (busy && tick_1hz) begin
        tick_pending <= 1'b1; // [R22]
      end else if (!busy) begin
        tick_pending <= 1'b0;
      end
      eval_tick <= TIME_TICK_O; // [R24]
    end
  end

  // ------------------------------------------------------------
  // alarm comparator
  // ------------------------------------------------------------
  logic [4:0] field_on;
  logic [4:0] field_eq;
  logic alarm_hit;
  assign field_on = ~{sec_match[7], min_match[7], hour_match[7], day_match[7],
                      wday_match[7]}; // [R2]
  assign field_eq = {(TIME_I.sec & acdt_pkg::SEC_VAL_MASK) == {1'b0, sec_match[6:0]},
                     (TIME_I.min & acdt_pkg::SEC_VAL_MASK) == {1'b0, min_match[6:0]},
                     (TIME_I.hour & acdt_pkg::HOUR_VAL_MASK) == {1'b0, hour_match[6:0]},
                     (TIME_I.day & acdt_pkg::DAY_VAL_MASK) == {1'b0, day_match[6:0]},
                     (TIME_I.wday & acdt_pkg::WDAY_VAL_MASK) == {1'b0, wday_match[6:0]}};
  assign alarm_hit = eval_tick & (|field_on) & (&(field_eq | ~field_on)); // [R3]
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ALARM_FLAG_O <= 1'b0;
    end else if (alarm_hit) begin
      ALARM_FLAG_O <= 1'b1; // [R3]
    end else if (ALARM_FLAG_CLEAR_I) begin
      ALARM_FLAG_O <= 1'b0; // [R4]
    end
  end

  // ------------------------------------------------------------
  // countdown timer
  // ------------------------------------------------------------
  logic run_d;
  logic cd_fire;
  logic cd_skip;
  assign cd_fire = cd_run & run_d & ~cd_skip & src_tick & (cd_load != 8'h00) &
                   (cd_count == 8'h01); // [R12]
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cd_count <= 8'h00;
      run_d <= 1'b0;
      cd_skip <= 1'b0;
    end else begin
      run_d <= cd_run;
      cd_skip <= (cd_run && !run_d) ? ~cd_ctrl[acdt_pkg::CTRL_SRC_LSB + 1]
                                    : (cd_skip & ~src_tick); // [R16]
      if (wr.valid && wr.addr == acdt_pkg::ADDR_CD_LOAD) begin
        cd_count <= wr.data; // [R13]
      end else if (cd_run && !run_d) begin
        cd_count <= cd_load; // [R16]
      end else if (cd_fire) begin
        cd_count <= cd_load; // [R12]
      end else if (cd_run && !cd_skip && src_tick && cd_count > 8'h01) begin
        cd_count <= cd_count - 8'h01; // [R11]
      end
    end
  end
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      COUNTDOWN_FLAG_O <= 1'b0;
    end else if (cd_fire) begin
      COUNTDOWN_FLAG_O <= 1'b1; // [R15]
    end else if (COUNTDOWN_FLAG_CLEAR_I) begin
      COUNTDOWN_FLAG_O <= 1'b0;
    end
  end

  logic [9:0] pulse_cnt;
  logic [9:0] pulse_width;
  always_comb begin
    case (cd_src)
      acdt_pkg::SRC_4096: pulse_width = (cd_load == 8'h01) ? acdt_pkg::PW_4096_T1
                                                          : acdt_pkg::PW_4096;
      acdt_pkg::SRC_64: pulse_width = (cd_load == 8'h01) ? acdt_pkg::PW_64_T1
                                                        : acdt_pkg::PW_SLOW;
      default: pulse_width = acdt_pkg::PW_SLOW;
    endcase
  end
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_cnt <= 10'h000;
    end else if (cd_fire) begin
      pulse_cnt <= pulse_width; // [R19]
    end else if (osc_tick && pulse_cnt != 10'h000) begin
      pulse_cnt <= pulse_cnt - 10'h001;
    end
  end

  // ------------------------------------------------------------
  // open-drain interrupt
  // ------------------------------------------------------------
  logic next_int;
  logic cd_int_src;
  assign cd_int_src = cd_pulse_mode ? (cd_fire | pulse_cnt != 10'h000) : COUNTDOWN_FLAG_O;
  assign next_int = (ALARM_IRQ_ENABLE_I & ALARM_FLAG_O) | (cd_ie & cd_int_src); // [R5] [R15]
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      INT_O <= 1'b0;
      INT_OE_N_O <= 1'b1;
    end else begin
      INT_O <= 1'b0;
      INT_OE_N_O <= ~next_int;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_reload_on_fire: assert property (cd_fire && !wr.valid |=> cd_count == $past(cd_load)) // [R12]
    else $error("count not reloaded after expiry");
  a_zero_halts: assert property (cd_load == 8'h00 && !wr.valid && run_d |=> $stable(cd_count)) // [R11]
    else $error("count moved with zero load");
  a_timer_flag_set: assert property (cd_fire |=> COUNTDOWN_FLAG_O ##1 !INT_OE_N_O || !$past(cd_ie)) // [R15]
    else $error("timer flag or interrupt missing");
  a_timer_flag_hold: assert property (COUNTDOWN_FLAG_O && !COUNTDOWN_FLAG_CLEAR_I |=> COUNTDOWN_FLAG_O) // [R15]
    else $error("timer flag dropped without clear");
  a_alarm_sets: assert property (alarm_hit |=> ALARM_FLAG_O) // [R3]
    else $error("alarm flag not set on match");
  a_alarm_on_tick: assert property ($rose(ALARM_FLAG_O) |-> $past(eval_tick)) // [R24]
    else $error("alarm flag set off a time update");
  a_alarm_irq: assert property (ALARM_IRQ_ENABLE_I && ALARM_FLAG_O |=> !INT_OE_N_O) // [R5]
    else $error("alarm interrupt not driven");
  a_pulse_width: assert property (cd_fire && cd_src == acdt_pkg::SRC_4096 && cd_load > 8'h01
                                  |=> pulse_cnt == 10'h008) // [R19]
    else $error("pulse width wrong at fast source");
  a_tick_held: assert property (busy |=> !TIME_TICK_O) // [R22]
    else $error("time advanced during access");
  a_pending_served: assert property (tick_pending && !busy |=> TIME_TICK_O) // [R22]
    else $error("pending time update lost");

  c_timer_fire: cover property (cd_fire ##1 COUNTDOWN_FLAG_O);
  c_alarm_set: cover property (alarm_hit ##1 ALARM_FLAG_O);
  c_pending_tick: cover property (busy && tick_1hz ##[1:1000] TIME_TICK_O);
  c_pulse_irq: cover property (cd_pulse_mode && cd_ie && cd_fire ##2 !INT_OE_N_O);
endmodule // acdt_top
`default_nettype wire

// ---- verif/acdt_host.sv ----
/*
  Host model of the three-wire serial port: command byte, then data bytes.
  Assumes the bench resolves the shared data line from the device output enable.
*/
`timescale 1ns/100ps
`default_nettype none
module acdt_host (
  input wire logic clk_i,
  input wire logic sdio_i,
  output logic ce_o,
  output logic scl_o,
  output logic sdio_o
);
  // ----
  // frame driver
  // ----
  localparam int HALF = 6;
  initial begin
    ce_o = 1'b0;
    scl_o = 1'b0;
    sdio_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // released line shows the inverse of its last level
  task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdio_o <= drive ? tx[i] : ~sdio_o;
      wait_clk(HALF);
      rx[i] = sdio_i;
      scl_o <= 1'b1;
      wait_clk(HALF);
      scl_o <= 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] wd [8],
                       output logic [7:0] rd [8]);
    logic [7:0] junk;
    ce_o <= 1'b1;
    wait_clk(HALF);
    xfer(cmd, 1'b1, junk);
    for (int k = 0; k < n; k++) xfer(wd[k], !cmd[7], rd[k]);
    wait_clk(HALF);
    ce_o <= 1'b0;
    sdio_o <= ~sdio_o;
    wait_clk(2 * HALF);
  endtask
endmodule // acdt_host
`default_nettype wire

// ---- verif/testbench.sv ----
/*
  Self-checking bench for the alarm and countdown block.
  Assumes the host model drives the serial port; calendar inputs held still.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ----
  // harness
  // ----
  localparam int TICK = 4883;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic alarm_irq_enable = 1'b0;
  logic cclr = 1'b0;
  logic ce, scl, hsd, sdo, oe_n, int_o, int_oe_n, tick, aflag, cflag;
  logic [4:0] ra;
  acdt_pkg::acdt_wr_t wr, last_wr;
  logic [7:0] wd [8];
  logic [7:0] rd [8];
  int n_mismatch = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int tick_cnt = 0;
  int cyc;
  wire logic sdio = !oe_n ? sdo : hsd;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (wr.valid === 1'b1) begin
      last_wr <= wr;
      wr_cnt <= wr_cnt + 1;
    end
  end
  acdt_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .SCL_I(scl), .SDIO_I(sdio),
    .SDIO_O(sdo), .SDIO_OE_N_O(oe_n), .INT_O(int_o), .INT_OE_N_O(int_oe_n), .TIME_I('0),
    .EXT_RDATA_I(8'h5A), .EXT_RD_ADDR_O(ra), .EXT_WR_O(wr), .TIME_TICK_O(tick),
    .ALARM_IRQ_ENABLE_I(alarm_irq_enable), .ALARM_FLAG_CLEAR_I(1'b0), .COUNTDOWN_FLAG_CLEAR_I(cclr),
    .CORR_ADD_I(1'b0), .CORR_DROP_I(1'b0), .ALARM_FLAG_O(aflag), .COUNTDOWN_FLAG_O(cflag));
  acdt_host u_host (.clk_i(clk), .sdio_i(sdio), .ce_o(ce), .scl_o(scl), .sdio_o(hsd));
  // ----
  // helpers
  // ----
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic span(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: interval %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic regs(input logic rnw, input logic [4:0] a, input int n, input logic [7:0] d);
    wd[0] = d;
    u_host.frame({rnw, acdt_pkg::CMD_SUBADDR, a}, n, wd, rd);
  endtask
  task automatic clr();
    cclr <= 1'b1;
    @(posedge clk);
    cclr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_flag(input int lim);
    cyc = 0;
    while (cflag !== 1'b1) begin
      @(posedge clk);
      cyc++;
      if (cyc > lim) begin
        n_mismatch++;
        $display("mismatch at %0t: countdown flag timeout", $time);
        end_sim();
      end
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    regs(1'b1, acdt_pkg::ADDR_SEC_MATCH, 7, 8'h00);
    for (int i = 0; i < 5; i++) check(rd[i], 8'h80);
    check(rd[5], 8'h00);
    check(rd[6], 8'h18);
    check({4'h0, int_o, aflag, cflag, int_oe_n}, 8'h01);
  endtask
  task automatic t_fields();
    wd = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    u_host.frame({1'b0, acdt_pkg::CMD_SUBADDR, acdt_pkg::ADDR_SEC_MATCH}, 5, wd, rd);
    wd[0] = 8'h00;
    u_host.frame({1'b0, 2'h2, acdt_pkg::ADDR_SEC_MATCH}, 1, wd, rd);
    regs(1'b1, acdt_pkg::ADDR_SEC_MATCH, 5, 8'h00);
    check(rd[0], 8'hFF);
    check(rd[1], 8'hFF);
    check(rd[2], 8'hBF);
    check(rd[3], 8'hBF);
    check(rd[4], 8'h87);
  endtask
  task automatic t_ext();
    regs(1'b0, 5'h12, 1, 8'h33);
    regs(1'b0, acdt_pkg::ADDR_SECONDS, 1, 8'h45);
    check(wr_cnt[7:0], 8'h01);
    check({3'h0, last_wr.addr}, 8'h04);
    check(last_wr.data, 8'h45);
    regs(1'b1, acdt_pkg::ADDR_SECONDS, 7, 8'h00);
    for (int i = 0; i < 7; i++) check(rd[i], 8'h5A);
    regs(1'b1, acdt_pkg::ADDR_LAST, 2, 8'h00);
    check(rd[0], 8'h18);
    check(rd[1], 8'h5A);
    check({3'h0, ra}, 8'h01);
  endtask
  task automatic t_level();
    longint t0;
    regs(1'b0, acdt_pkg::ADDR_CD_LOAD, 1, 8'h03);
    regs(1'b0, acdt_pkg::ADDR_CD_CTRL, 1, 8'h06);
    wait_flag(5 * TICK);
    span(cyc, 3 * TICK - 40, 4 * TICK);
    t0 = $time;
    repeat (2) @(posedge clk);
    check({7'h00, int_oe_n}, 8'h00);
    clr();
    check({6'h00, cflag, int_oe_n}, 8'h01);
    repeat (TICK * 3 / 2) @(posedge clk);
    regs(1'b1, acdt_pkg::ADDR_CD_LOAD, 1, 8'h00);
    check(rd[0], 8'h02);
    regs(1'b1, acdt_pkg::ADDR_CD_LOAD, 1, 8'h00);
    check(rd[0], 8'h02);
    wait_flag(3 * TICK);
    span(int'(($time - t0) / 50), 14645, 14652);
  endtask
  task automatic t_pulse();
    regs(1'b0, acdt_pkg::ADDR_CD_CTRL, 1, 8'h00);
    regs(1'b0, acdt_pkg::ADDR_CD_LOAD, 1, 8'h01);
    clr();
    regs(1'b0, acdt_pkg::ADDR_CD_CTRL, 1, 8'h07);
    wait_flag(3 * TICK);
    cyc = 0;
    repeat (2) @(posedge clk);
    while (int_oe_n === 1'b0 && cyc < 3000) begin
      @(posedge clk);
      cyc++;
    end
    span(cyc, 2436, 2444);
    check({7'h00, cflag}, 8'h01);
  endtask
  task automatic t_halt();
    regs(1'b0, acdt_pkg::ADDR_CD_CTRL, 1, 8'h00);
    regs(1'b0, acdt_pkg::ADDR_CD_LOAD, 1, 8'h00);
    clr();
    regs(1'b0, acdt_pkg::ADDR_CD_CTRL, 1, 8'h06);
    repeat (4 * TICK) @(posedge clk);
    check({6'h00, cflag, int_oe_n}, 8'h01);
    regs(1'b0, acdt_pkg::ADDR_CD_CTRL, 1, 8'h18);
    check(tick_cnt[7:0], 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    alarm_irq_enable <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_fields();
    t_ext();
    t_level();
    t_pulse();
    t_halt();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
